// File: rtl/lmd_map.svh
`ifndef LMD_MAP_SVH
`define LMD_MAP_SVH

`define LMD_COLS 128
`define LMD_ROWS 34
`define LMD_RAM_WORDS 768
`define LMD_EVEN_ROWS 6'h11
`define LMD_LAST_STEP 6'h21
`define LMD_LAST_COL 7'h7F
`define LMD_LAST_BANK 3'h4
`define LMD_ICON_BANK 3'h5
`define LMD_ICON_ROW 6'h21
`define LMD_LOW_ROW 6'h20
`define LMD_ICON_BIT 3'h4
`define LMD_ICON_MASK 8'h10
`define LMD_LOW_MASK 8'h01

`define LMD_CLK_NS 25
`define LMD_OSC_NS 5000
`define LMD_OSC_CYC ((`LMD_OSC_NS + `LMD_CLK_NS - 1) / `LMD_CLK_NS)
`define LMD_EXT_IDLE_NS 2000
`define LMD_EXT_IDLE_CYC (`LMD_EXT_IDLE_NS / `LMD_CLK_NS)
`define LMD_LINE_TICKS 32

`define LMD_CMD_FUNC_TOP 5'h04
`define LMD_CMD_DISP_TOP 5'h01
`define LMD_CMD_YSET_TOP 5'h08
`define LMD_CMD_MULT_TOP 6'h01
`define LMD_CMD_PD_BIT 2
`define LMD_CMD_V_BIT 1
`define LMD_CMD_D_BIT 2
`define LMD_MULT_BASE 3'h2

`define LMD_SYN_OSC 0
`define LMD_SYN_CLR 1
`define LMD_SYN_STRAP 2
`define LMD_SYN_POR 3
`define LMD_SYN_LSB 4
`define LMD_SYN_SCL 5
`define LMD_SYN_SDA 6

`endif

// File: rtl/lmd_pkg.sv
package lmd_pkg;
  typedef enum logic [2:0] {LMD_I2C_IDLE, LMD_I2C_ADDR, LMD_I2C_CTRL, LMD_I2C_DATA,
    LMD_I2C_IGNORE} lmd_i2c_t;
  typedef logic [2:0] lmd_mult_t;
  typedef logic [127:0] lmd_cols_t;
  typedef logic [33:0] lmd_rows_t;
endpackage

// File: rtl/lmd_core.sv
`include "lmd_map.svh"
// Function
// RULE1: internal oscillator unless external clock toggles
// RULE2: slave receiver only, never drives clock
// RULE3: address bit 0 taken from strap pin
// RULE4: acknowledge driven low on separate output
// RULE5: active-low external clear pin resets chip
// RULE6: strap high enables power-on reset source
// RULE7: after reset outputs grounded, power-down on
// RULE8: power-down stops timing, bus stays alive
// RULE9: display RAM six banks of 128 bytes
// RULE10: column address maps to same column output
// RULE11: 128 column outputs from latched row data
// RULE12: 34 row outputs, top row icons
// RULE13: rows scanned even ascending, then odd
// RULE14: command decode routes data to RAM/instruction
// RULE15: write address counter addresses every RAM write
// RULE16: separate display counter fetches RAM rows
// RULE17: scan runs undisturbed during bus writes
// RULE18: programmable multiplier factor two to five
// RULE19: horizontal mode: column wraps, bank increments
// RULE20: vertical mode: bank wraps at four, column increments
// RULE21: icon bank five stores only fifth bit
// RULE22: combined reset, synchronous release
module lmd_core #(
  parameter logic [5:0] ADDR_HI = 6'h1E,
  parameter int LINE_TICKS = `LMD_LINE_TICKS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic display_clock_input,
  input wire logic external_clear_n,
  input wire logic por_enable_strap,
  input wire logic por_detect,
  input wire logic slave_addr_lsb_pin,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic ack_drive_out,
  output logic ack_drive_oe,
  output logic powerdown_flag,
  output lmd_pkg::lmd_mult_t mult_factor,
  output lmd_pkg::lmd_cols_t column_drive_lines,
  output lmd_pkg::lmd_rows_t row_drive_lines
);
  import lmd_pkg::*;

  function automatic logic [5:0] step_to_row(input logic [5:0] step);
    if (step < `LMD_EVEN_ROWS)
      step_to_row = {step[4:0], 1'b0};
    else
      step_to_row = {step[4:0] - 5'h11, 1'b1};
  endfunction

  function automatic logic [2:0] row_bank(input logic [5:0] row);
    if (row == `LMD_ICON_ROW)
      row_bank = `LMD_ICON_BANK;
    else
      row_bank = row[5:3];
  endfunction

  function automatic logic [2:0] row_bit(input logic [5:0] row);
    if (row == `LMD_ICON_ROW)
      row_bit = `LMD_ICON_BIT;
    else
      row_bit = row[2:0];
  endfunction

  function automatic logic [7:0] bank_mask(input logic [2:0] bank, input logic [7:0] d);
    if (bank == `LMD_ICON_BANK)
      bank_mask = d & `LMD_ICON_MASK;
    else if (bank == `LMD_LAST_BANK)
      bank_mask = d & `LMD_LOW_MASK;
    else
      bank_mask = d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and reset

  logic [6:0] sync1;
  logic [6:0] sync2;
  logic [1:0] rst_pipe;
  logic raw_rst;
  logic core_rst;

  always_ff @(posedge ref_clk)
  begin
    sync1 <= {sda_in, scl_in, slave_addr_lsb_pin, por_detect, por_enable_strap,
      external_clear_n, display_clock_input};
    sync2 <= sync1;
  end

  // pin always honoured; power-on source only with strap high
  assign raw_rst = rst | ~sync2[`LMD_SYN_CLR] | // RULE5
    (sync2[`LMD_SYN_STRAP] & sync2[`LMD_SYN_POR]); // RULE6

  // async assert, clean release so counters start together
  always_ff @(posedge ref_clk or posedge raw_rst)
  begin
    if (raw_rst)
      rst_pipe <= 2'h3; // RULE22
    else
      rst_pipe <= {rst_pipe[0], 1'b0};
  end
  assign core_rst = rst_pipe[1];

  ////////////////////////////////////////////////////////////////////////////////
  // bus receiver

  lmd_i2c_t state;
  logic scl_d;
  logic sda_d;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic co_flag;
  logic dc_flag;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic byte_end;
  logic byte_stb;
  logic cmd_stb;
  logic ram_stb;
  logic addr_hit;

  assign scl_rise = sync2[`LMD_SYN_SCL] & ~scl_d;
  assign scl_fall = ~sync2[`LMD_SYN_SCL] & scl_d;
  assign start_c = scl_d & sync2[`LMD_SYN_SCL] & sda_d & ~sync2[`LMD_SYN_SDA];
  assign stop_c = scl_d & sync2[`LMD_SYN_SCL] & ~sda_d & sync2[`LMD_SYN_SDA];
  assign byte_end = scl_fall & (bit_cnt == 4'h8);
  assign addr_hit = (shreg[7:1] == {ADDR_HI, sync2[`LMD_SYN_LSB]}) & ~shreg[0]; // RULE3
  assign byte_stb = byte_end & (state == LMD_I2C_DATA);
  assign cmd_stb = byte_stb & ~dc_flag; // RULE14
  assign ram_stb = byte_stb & dc_flag; // RULE14

  always_ff @(posedge ref_clk)
  begin
    scl_d <= sync2[`LMD_SYN_SCL];
    sda_d <= sync2[`LMD_SYN_SDA];
  end

  // only samples the clock line; no output exists for it
  always_ff @(posedge ref_clk)
  begin
    if (core_rst)
    begin
      state <= LMD_I2C_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      co_flag <= 1'b0;
      dc_flag <= 1'b0;
    end
    else if (start_c)
    begin
      state <= LMD_I2C_ADDR; // RULE2
      bit_cnt <= 4'h0;
    end
    else if (stop_c)
      state <= LMD_I2C_IDLE;
    else if (scl_rise && bit_cnt < 4'h8)
    begin
      shreg <= {shreg[6:0], sync2[`LMD_SYN_SDA]};
      bit_cnt <= bit_cnt + 4'h1;
    end
    else if (byte_end)
    begin
      bit_cnt <= 4'h9;
      case (state)
        LMD_I2C_ADDR: state <= addr_hit ? LMD_I2C_CTRL : LMD_I2C_IGNORE;
        LMD_I2C_CTRL:
        begin
          co_flag <= shreg[7];
          dc_flag <= shreg[6];
          state <= LMD_I2C_DATA;
        end
        LMD_I2C_DATA: state <= co_flag ? LMD_I2C_CTRL : LMD_I2C_DATA; // RULE14
        LMD_I2C_IGNORE: state <= LMD_I2C_IGNORE;
        default: state <= LMD_I2C_IDLE;
      endcase
    end
    else if (scl_fall && bit_cnt == 4'h9)
      bit_cnt <= 4'h0;
  end

  // open-drain: only ever pulls low, released on the next falling clock
  always_ff @(posedge ref_clk)
  begin
    if (core_rst || start_c || stop_c)
    begin
      ack_drive_oe <= 1'b0;
      ack_drive_out <= 1'b1;
    end
    else if (byte_end)
    begin
      ack_drive_oe <= (state == LMD_I2C_ADDR) ? addr_hit : // RULE4
        (state == LMD_I2C_CTRL || state == LMD_I2C_DATA);
      ack_drive_out <= 1'b0;
    end
    else if (scl_fall && bit_cnt == 4'h9)
    begin
      ack_drive_oe <= 1'b0;
      ack_drive_out <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // instruction registers and write address counter

  logic vmode;
  logic disp_on;
  logic [6:0] wr_x;
  logic [2:0] wr_y;

  always_ff @(posedge ref_clk)
  begin
    if (core_rst)
    begin
      powerdown_flag <= 1'b1; // RULE7
      vmode <= 1'b0;
    end
    else if (cmd_stb && shreg[7:3] == `LMD_CMD_FUNC_TOP)
    begin
      powerdown_flag <= shreg[`LMD_CMD_PD_BIT];
      vmode <= shreg[`LMD_CMD_V_BIT];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (core_rst)
      disp_on <= 1'b0;
    else if (cmd_stb && shreg[7:3] == `LMD_CMD_DISP_TOP)
      disp_on <= shreg[`LMD_CMD_D_BIT];
  end

  always_ff @(posedge ref_clk)
  begin
    if (core_rst)
      mult_factor <= `LMD_MULT_BASE;
    else if (cmd_stb && shreg[7:2] == `LMD_CMD_MULT_TOP)
      mult_factor <= `LMD_MULT_BASE + {1'b0, shreg[1:0]}; // RULE18
  end

  always_ff @(posedge ref_clk)
  begin
    if (core_rst)
    begin
      wr_x <= 7'h00;
      wr_y <= 3'h0;
    end
    else if (cmd_stb && shreg[7])
      wr_x <= shreg[6:0];
    else if (cmd_stb && shreg[7:3] == `LMD_CMD_YSET_TOP && shreg[2:0] <= `LMD_ICON_BANK)
      wr_y <= shreg[2:0];
    else if (ram_stb)
    begin
      if (wr_y == `LMD_ICON_BANK)
        wr_x <= wr_x + 7'h01; // RULE21
      else if (vmode)
      begin
        wr_y <= (wr_y == `LMD_LAST_BANK) ? 3'h0 : wr_y + 3'h1; // RULE20
        if (wr_y == `LMD_LAST_BANK)
          wr_x <= wr_x + 7'h01; // RULE20
      end
      else
      begin
        wr_x <= wr_x + 7'h01; // RULE19
        if (wr_x == `LMD_LAST_COL)
          wr_y <= (wr_y == `LMD_LAST_BANK) ? 3'h0 : wr_y + 3'h1; // RULE19
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // display RAM, write port independent of the scan read

  logic [7:0] mem [0:`LMD_RAM_WORDS-1];

  always_ff @(posedge ref_clk)
  begin
    if (ram_stb)
      mem[{wr_y, wr_x}] <= bank_mask(wr_y, shreg); // RULE9 RULE15 RULE21
  end

  ////////////////////////////////////////////////////////////////////////////////
  // display clock and scan timing

  localparam int OSC_CYC = `LMD_OSC_CYC;
  localparam int EXT_IDLE_CYC = `LMD_EXT_IDLE_CYC;
  logic osc_d;
  logic osc_rise;
  logic [7:0] idle_cnt;
  logic ext_mode;
  logic [7:0] int_cnt;
  logic disp_tick;
  logic [7:0] tick_cnt;
  logic line_tick;
  logic [5:0] row_step;

  assign osc_rise = sync2[`LMD_SYN_OSC] & ~osc_d;
  assign ext_mode = idle_cnt != 8'(EXT_IDLE_CYC);

  always_ff @(posedge ref_clk)
  begin
    osc_d <= sync2[`LMD_SYN_OSC];
  end

  // a pin held high falls back to the internal oscillator after the idle time
  always_ff @(posedge ref_clk)
  begin
    if (core_rst)
      idle_cnt <= 8'(EXT_IDLE_CYC);
    else if (osc_rise)
      idle_cnt <= 8'h00; // RULE1
    else if (ext_mode)
      idle_cnt <= idle_cnt + 8'h01;
  end

  always_ff @(posedge ref_clk)
  begin
    if (core_rst || powerdown_flag || ext_mode)
      int_cnt <= 8'h00; // RULE8
    else if (int_cnt == 8'(OSC_CYC - 1))
      int_cnt <= 8'h00;
    else
      int_cnt <= int_cnt + 8'h01;
  end

  assign disp_tick = ~powerdown_flag & (ext_mode ? osc_rise : // RULE1
    (int_cnt == 8'(OSC_CYC - 1))); // RULE8
  assign line_tick = disp_tick & (tick_cnt == 8'(LINE_TICKS - 1));

  always_ff @(posedge ref_clk)
  begin
    if (core_rst)
      tick_cnt <= 8'h00;
    else if (line_tick)
      tick_cnt <= 8'h00;
    else if (disp_tick)
      tick_cnt <= tick_cnt + 8'h01;
  end

  always_ff @(posedge ref_clk)
  begin
    if (core_rst)
      row_step <= `LMD_LAST_STEP;
    else if (line_tick)
      row_step <= (row_step == `LMD_LAST_STEP) ? 6'h00 : row_step + 6'h01; // RULE13
  end

  ////////////////////////////////////////////////////////////////////////////////
  // display address counter and row latch

  logic fetch_busy;
  logic [6:0] fetch_col;
  logic [5:0] fetch_row;
  logic present_stb;
  logic [127:0] shadow;
  logic [5:0] next_row;

  assign next_row = step_to_row((row_step == `LMD_LAST_STEP) ? 6'h00 : row_step + 6'h01);

  // one byte per cycle keeps a whole row under one line period
  always_ff @(posedge ref_clk)
  begin
    if (core_rst)
    begin
      fetch_busy <= 1'b0;
      fetch_col <= 7'h00;
      fetch_row <= 6'h00;
      present_stb <= 1'b0;
    end
    else
    begin
      present_stb <= fetch_busy & (fetch_col == `LMD_LAST_COL);
      if (line_tick)
      begin
        fetch_busy <= 1'b1; // RULE16
        fetch_col <= 7'h00;
        fetch_row <= next_row; // RULE13
      end
      else if (fetch_busy)
      begin
        fetch_col <= fetch_col + 7'h01; // RULE17
        if (fetch_col == `LMD_LAST_COL)
          fetch_busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (fetch_busy)
      shadow[fetch_col] <= mem[{row_bank(fetch_row), fetch_col}][row_bit(fetch_row)]; // RULE10
  end

  // no drive while dark; polarity inversion is left to the analog stage
  always_ff @(posedge ref_clk)
  begin
    if (core_rst || powerdown_flag || !disp_on)
    begin
      column_drive_lines <= '0; // RULE7 RULE8
      row_drive_lines <= '0;
    end
    else if (present_stb)
    begin
      column_drive_lines <= shadow; // RULE11
      row_drive_lines <= 34'h1 << fetch_row; // RULE12
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence seq_fetch_run;
    fetch_busy [*8];
  endsequence

  sequence seq_row_one;
    (row_step == 6'h11) ##0 (fetch_row == 6'h01);
  endsequence

  AST_RESET_DARK: assert property (core_rst |=> powerdown_flag ##1 // RULE7
    (row_drive_lines == '0 && column_drive_lines == '0))
    else $error("outputs not dark after reset");
  AST_PD_STILL: assert property (powerdown_flag |=> !line_tick && // RULE8
    row_drive_lines == '0)
    else $error("scan active in power-down");
  AST_ACK_LOW: assert property (ack_drive_oe |-> !ack_drive_out && bit_cnt == 4'h9) // RULE4
    else $error("acknowledge drive wrong");
  AST_ADDR_LSB: assert property ($rose(ack_drive_oe) && state == LMD_I2C_CTRL |-> // RULE3
    shreg[1] == sync2[`LMD_SYN_LSB])
    else $error("address bit 0 mismatch acknowledged");
  AST_HWRAP: assert property (ram_stb && !vmode && wr_y < `LMD_LAST_BANK && // RULE19
    wr_x == `LMD_LAST_COL |=> wr_x == 7'h00 && wr_y == $past(wr_y) + 3'h1)
    else $error("horizontal wrap wrong");
  AST_VWRAP: assert property (ram_stb && vmode && wr_y == `LMD_LAST_BANK && // RULE20
    wr_x != `LMD_LAST_COL |=> wr_y == 3'h0 && wr_x == $past(wr_x) + 7'h01)
    else $error("vertical wrap wrong");
  AST_ICON_BIT: assert property (ram_stb && wr_y == `LMD_ICON_BANK |=> // RULE21
    mem[{$past(wr_y), $past(wr_x)}] == ($past(shreg) & `LMD_ICON_MASK))
    else $error("icon byte not masked");
  AST_ROW_ORDER: assert property (line_tick && row_step == 6'h10 |=> seq_row_one) // RULE13
    else $error("odd rows not after even rows");
  AST_FETCH_LEN: assert property (line_tick && !core_rst |=> // RULE16
    seq_fetch_run ##121 present_stb)
    else $error("row fetch not 128 cycles");
  AST_SCAN_UNDISTURBED: assert property (fetch_busy && ram_stb && !line_tick && // RULE17
    fetch_col != `LMD_LAST_COL |=> fetch_busy && fetch_col == $past(fetch_col) + 7'h01)
    else $error("bus write stalled scan");
  AST_MULT: assert property (cmd_stb && shreg[7:2] == `LMD_CMD_MULT_TOP |=> // RULE18
    mult_factor == 3'($past(shreg) & 8'h03) + 3'h2 && mult_factor <= 3'h5)
    else $error("multiplier factor wrong");
endmodule

// File: bench/lmd_i2c_master.sv
module lmd_i2c_master (
  input wire logic ref_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // open drain: 1 means released, the pull-up wins
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // only this side ever moves the bus clock
  task automatic start();
    cyc(1);
    sda <= 1'b0;
    cyc(4);
    scl <= 1'b0;
  endtask
  // low phase 5, high phase 4: ack must clear before the next rise
  task automatic bit_io(input logic b, output logic s);
    cyc(2);
    sda <= b;
    cyc(3);
    scl <= 1'b1;
    cyc(4);
    s = sda_line;
    scl <= 1'b0;
  endtask
  // caller picks the address lsb; ninth bit released and sampled
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], s);
    bit_io(1'b1, ack);
  endtask
  task automatic stop();
    cyc(2);
    sda <= 1'b0;
    cyc(3);
    scl <= 1'b1;
    cyc(4);
    sda <= 1'b1;
    cyc(4);
  endtask
endmodule

// File: bench/lmd_core_tb.sv
module lmd_core_tb import lmd_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] A_HI = 6'h1E;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic dci = 1'b1;
  logic ext_en = 1'b1;
  logic clr_n = 1'b1;
  logic strap = 1'b1;
  logic por = 1'b0;
  logic lsb = 1'b1;
  logic scl, sda, sda_line, ack_out, ack_oe, pd;
  lmd_mult_t mult;
  lmd_cols_t cols;
  lmd_rows_t rows;
  lmd_rows_t prow = '0;
  logic [7:0] ram [0:5][0:127];
  int x = 0, y = 0, v = 0, nrow = 0, pr = 0, seed = 8;
  int n_mismatch = 0, n_compared = 0;
  ////////////////////////////////////////////////////////////////////////////
  assign sda_line = sda & ~(ack_oe & ~ack_out);
  initial
    forever #12.5 ref_clk = ~ref_clk;
  // pin held high selects the internal oscillator
  initial
    forever #100 dci = ext_en ? ~dci : 1'b1;
  lmd_core #(.ADDR_HI(A_HI), .LINE_TICKS(32)) uut (
    .ref_clk(ref_clk), .rst(rst), .display_clock_input(dci), .external_clear_n(clr_n),
    .por_enable_strap(strap), .por_detect(por), .slave_addr_lsb_pin(lsb), .scl_in(scl),
    .sda_in(sda_line), .ack_drive_out(ack_out), .ack_drive_oe(ack_oe),
    .powerdown_flag(pd), .mult_factor(mult), .column_drive_lines(cols),
    .row_drive_lines(rows)
  );
  lmd_i2c_master m (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda(sda));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_v(input logic [127:0] g, input logic [127:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_b(input logic g, input logic e);
    chk_v(128'(g), 128'(e));
  endtask
  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  function automatic lmd_cols_t exp_cols(input int r);
    for (int c = 0; c < 128; c++)
      exp_cols[c] = r < 32 ? ram[r / 8][c][r % 8] : ram[r == 32 ? 4 : 5][c][r == 32 ? 0 : 4];
  endfunction
  function automatic int succ(input int p);
    return p == 32 ? 1 : p == 33 ? 0 : p + 2;
  endfunction
  function automatic int ridx(input lmd_rows_t rw);
    ridx = 0;
    for (int i = 0; i < 34; i++)
      if (rw[i])
        ridx = i;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic put(input logic [7:0] b, input logic e);
    logic a;
    m.send(b, a);
    chk_b(a, e);
  endtask
  task automatic hdr(input logic [7:0] c);
    m.start();
    put({A_HI, lsb, 1'b0}, 1'b0);
    put(c, 1'b0);
  endtask
  task automatic cmd(input logic [7:0] b);
    hdr(8'h00);
    put(b, 1'b0);
    m.stop();
  endtask
  task automatic setxy(input int nx, input int ny);
    cmd(8'h80 | 8'(nx));
    cmd(8'h40 | 8'(ny));
    x = nx;
    y = ny;
  endtask
  // model of the write pointer; x is stepped first, y needs the old x
  task automatic dat(input logic [7:0] b);
    int ox;
    put(b, 1'b0);
    ram[y][x] = b;
    ox = x;
    x = (y == 5 || v == 0 || y == 4) ? (x + 1) % 128 : x;
    y = (y == 5) ? 5 : (v != 0 || ox == 127) ? (y + 1) % 5 : y;
  endtask
  task automatic wait_rows(input int n, input int lim);
    repeat (lim)
    begin
      if (nrow >= n)
        break;
      @(posedge ref_clk);
    end
    chk_b(nrow >= n, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // every new row: one-hot, interlaced successor, columns from the model
  always @(negedge ref_clk)
    if (rows !== prow)
    begin
      if (rows !== 34'h0)
      begin
        chk_v(128'($countones(rows)), 128'h1);
        if (prow !== 34'h0)
          chk_v(128'(ridx(rows)), 128'(succ(pr)));
        chk_v(cols, exp_cols(ridx(rows)));
        pr = ridx(rows);
        nrow++;
      end
      prow = rows;
    end
  initial
  begin
    #2_500_000;
    n_mismatch++;
    close_out();
  end
  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (12) @(posedge ref_clk);
    chk_b(pd, 1'b1);
    chk_v(128'(mult), 128'h2);
    chk_v(cols | 128'(rows), '0);
    chk_b(ack_oe, 1'b0);
    m.start();
    put({A_HI, ~lsb, 1'b0}, 1'b1);
    m.stop();
    for (int s = 0; s < 4; s++)
    begin
      cmd(8'h04 | 8'(s));
      chk_v(128'(mult), 128'(s + 2));
    end
    // fill banks 0..4 plus one byte past the last address
    setxy(0, 0);
    hdr(8'h40);
    for (int i = 0; i < 641; i++)
      dat(8'($random(seed)));
    m.stop();
    setxy(0, 5);
    hdr(8'h40);
    for (int i = 0; i < 128; i++)
      dat(8'($random(seed)));
    m.stop();
    cmd(8'h26);
    v = 1;
    setxy(5, 3);
    hdr(8'h40);
    for (int i = 0; i < 3; i++)
      dat(8'($random(seed)));
    m.stop();
    cmd(8'h0C);
    cmd(8'h20);
    v = 0;
    wait_rows(4, 4000);
    cmd(8'h07);
    chk_v(128'(mult), 128'h5);
    wait_rows(36, 12000);
    ext_en <= 1'b0;
    wait_rows(nrow + 1, 8000);
    cmd(8'h24);
    repeat (10) @(posedge ref_clk);
    chk_b(pd, 1'b1);
    chk_v(cols | 128'(rows), '0);
    strap <= 1'b0;
    por <= 1'b1;
    repeat (10) @(posedge ref_clk);
    por <= 1'b0;
    repeat (10) @(posedge ref_clk);
    chk_v(128'(mult), 128'h5);
    strap <= 1'b1;
    por <= 1'b1;
    repeat (6) @(posedge ref_clk);
    por <= 1'b0;
    repeat (12) @(posedge ref_clk);
    chk_v(128'(mult), 128'h2);
    cmd(8'h07);
    cmd(8'h20);
    clr_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    clr_n <= 1'b1;
    repeat (12) @(posedge ref_clk);
    chk_b(pd, 1'b1);
    chk_v(128'(mult) | cols | 128'(rows), 128'h2);
    // strap moved: only the new address may be acknowledged
    lsb <= 1'b0;
    repeat (12) @(posedge ref_clk);
    cmd(8'h05);
    chk_v(128'(mult), 128'h3);
    close_out();
  end
endmodule
